/* rtl/bitman_consts.svh */
// Constants of the bit-manipulation execute unit: opcodes, offsets, fields, resets
`ifndef BITMAN_CONSTS_SVH
`define BITMAN_CONSTS_SVH

// ==========================================================
// Single-byte opcodes
`define OP_TEST_POSITIVE_OP_GF 8'h01
`define OP_CLR_GF 8'h02
`define OP_SET_GF 8'h03
`define OP_TEST_POSITIVE_OP_CF 8'h04
`define OP_TEST_POSITIVE_OP_ZF 8'h0e
`define OP_SET_PTR 8'h34
`define OP_TEST_PTR 8'h37
// Upper five bits of the pointer-pair bit group; bit 2 picks clear
`define OP_HL_GROUP 5'h0a
`define OP_HL_CLR_POS 2

// ==========================================================
// Two-byte prefixes and second-byte sub-operations
`define OP_PFX_MEM 8'h39
`define OP_PFX_PORT 8'h3b
`define SUB_SET 2'b00
`define SUB_TEST 2'b10
`define SUB_TEST_POSITIVE_OP 2'b11
// Pointer ports sit at port numbers four to seven
`define PTR_PORT_HI 2'b01
`define PAGE0_HI 4'h0

// ==========================================================
// Register map, byte addresses
`define REG_FLAGS 12'h000
`define REG_POINTER 12'h004
`define REG_STATUS 12'h008
`define MEM_WIN_HI 2'b01

// ==========================================================
// Field positions and reset values
`define FLAG_CF 0
`define FLAG_ZF 1
`define FLAG_GF 2
`define FLAG_SF 3
`define STATUS_PEND 8
`define FLAGS_RESET 4'h0
`define POINTER_RESET 4'h0
`define FIRST_RESET 8'h00

`endif

/* rtl/bitman_pkg.sv */
// Types shared by the bit-manipulation execute unit
package bitman_pkg;

   // ==========================================================
   // Instruction fetch state
   typedef enum logic {ST_FIRST, ST_SECOND} fetch_state_t;

endpackage

/* rtl/data_nibble_ram.sv */
// Nibble-wide data memory with one write port and two read ports
`timescale 1ns/1ps
`default_nettype none

module data_nibble_ram #(
   parameter int ADDR_W = 8
) (
   input wire logic clock,
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [3:0] wdata,
   input wire logic [ADDR_W-1:0] raddr_a,
   input wire logic [ADDR_W-1:0] raddr_b,
   output logic [3:0] rdata_a,
   output logic [3:0] rdata_b
);

   // No reset: contents are undefined until written
   logic [3:0] mem_q [0:(1<<ADDR_W)-1];

   always_ff @(posedge clock)
   begin
      if (we)
      begin
         mem_q[waddr] <= wdata;
      end
   end

   // Read-modify-write in one cycle needs the asynchronous read
   assign rdata_a = mem_q[raddr_a];
   assign rdata_b = mem_q[raddr_b];

endmodule

`default_nettype wire

/* rtl/bit_port_bank.sv */
// Port output latches with bit set and bit read-back
`timescale 1ns/1ps
`default_nettype none

module bit_port_bank #(
   parameter int NPORT = 16,
   parameter logic [NPORT-1:0] OUT_MASK = 16'h000f
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic set_en,
   input wire logic [3:0] set_port,
   input wire logic [1:0] set_bit,
   input wire logic [3:0] rd_port,
   input wire logic [1:0] rd_bit,
   input wire logic rd_pin_only,
   input wire logic [NPORT*4-1:0] pin_in,
   output logic [NPORT*4-1:0] latch_out,
   output logic rd_value
);

   logic [NPORT*4-1:0] latch_q;
   logic [NPORT*4-1:0] latch_d;

   for (genvar i = 0; i < NPORT; i++)
   begin : g_port
      assign latch_d[i*4 +: 4] = latch_q[i*4 +: 4] |
         ((set_en && set_port == 4'(i)) ? (4'h1 << set_bit) : 4'h0);
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         latch_q <= '0;
      end
      else
      begin
         latch_q <= latch_d;
      end
   end

   assign latch_out = latch_q;
   // Output ports read back their latch unless rd_pin_only is set, all others the pin
   assign rd_value = (OUT_MASK[rd_port] && !rd_pin_only) ? latch_q[{rd_port, rd_bit}]
      : pin_in[{rd_port, rd_bit}];

endmodule

`default_nettype wire

/* rtl/bit_manipulation_exec_unit.sv */
// Bit-manipulation instruction decode and execute unit with Avalon-MM registers
// Contract
// - Test of a page-0 memory bit loads the status flag with the inverted bit.
// - Test of a port bit loads the status flag with the inverted latch or pin bit.
// - Pointer port test takes low pointer 3:2 plus four as port, 1:0 as bit, inverted pin.
// - Test-positive carry copies carry into status, then sets carry to one.
// - Test-positive zero copies the zero flag into status and leaves other flags.
// - Test-positive general copies the general flag into status.
// - Test-positive of a page-0 memory bit copies the bit into status.
// - Test-positive of a port bit copies latch or pin bit into status.
// - Set-general writes one to the general flag and one to status.
// - Clear-general writes zero to the general flag and one to status.
// - Set of a pointer-pair memory bit writes that bit to one and status to one.
// - Set of a page-0 memory bit writes that bit to one and status to one.
// - Set of a port bit writes the latch bit to one and status to one.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bitman_consts.svh"

module bit_manipulation_exec_unit #(
   parameter logic [15:0] OUT_PORT_MASK = 16'h000f
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic ins_valid,
   input wire logic [7:0] ins_byte,
   output logic ins_ready,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [63:0] port_pin_in,
   output logic [63:0] port_latch_out,
   output logic status_flag,
   output logic carry_flag,
   output logic zero_flag,
   output logic general_flag
);

   // ==========================================================
   // State
   bitman_pkg::fetch_state_t st_q;
   bitman_pkg::fetch_state_t st_d;
   logic [7:0] first_q;
   logic [7:0] first_d;
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   logic [3:0] hi_ptr_q;
   logic [3:0] hi_ptr_d;
   logic [3:0] low_pointer_q;
   logic [3:0] low_pointer_d;
   logic rd_done_q;
   logic rd_done_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   logic exec_one;
   logic exec_two;
   logic exec_any;
   logic is_mem2;
   logic is_port2;
   logic is_hl_op;
   logic [1:0] sub_op;
   logic [1:0] bsel;
   logic [3:0] operand;
   logic [7:0] ram_raddr_a;
   logic [3:0] ram_rd_a;
   logic [3:0] ram_rd_b;
   logic ram_we;
   logic [7:0] ram_waddr;
   logic [3:0] ram_wdata;
   logic mem_bit;
   logic mem_hit;
   logic port_set_en;
   logic [3:0] port_sel;
   logic [1:0] port_bit;
   logic port_pin_only;
   logic port_val;
   logic bus_wr;

   function automatic logic [3:0] bit_mask(input logic [1:0] idx);
      bit_mask = 4'h1 << idx;
   endfunction

   // ==========================================================
   // Decode
   assign ins_ready = 1'b1;
   assign sub_op = ins_byte[7:6];
   assign operand = ins_byte[3:0];
   assign bsel = (st_q == bitman_pkg::ST_SECOND) ? ins_byte[5:4] : ins_byte[1:0];
   assign exec_one = ins_valid && st_q == bitman_pkg::ST_FIRST &&
      ins_byte != `OP_PFX_MEM && ins_byte != `OP_PFX_PORT;
   assign exec_two = ins_valid && st_q == bitman_pkg::ST_SECOND;
   // Bus writes wait while an instruction executes, so no flag has two writers
   assign exec_any = exec_one || exec_two;
   assign is_mem2 = exec_two && first_q == `OP_PFX_MEM;
   assign is_port2 = exec_two && first_q == `OP_PFX_PORT;
   assign is_hl_op = exec_one && ins_byte[7:3] == `OP_HL_GROUP;
   assign mem_hit = avs_address[11:10] == `MEM_WIN_HI;
   assign bus_wr = avs_write && !exec_any && avs_byteenable[0];

   // ==========================================================
   // Data memory access
   assign ram_raddr_a = (st_q == bitman_pkg::ST_SECOND) ? {`PAGE0_HI, operand}
      : {hi_ptr_q, low_pointer_q};
   assign mem_bit = |(ram_rd_a & bit_mask(bsel));

   always_comb
   begin
      ram_we = 1'b0;
      ram_waddr = ram_raddr_a;
      ram_wdata = ram_rd_a;
      if (is_hl_op && !ins_byte[`OP_HL_CLR_POS])
      begin
         ram_we = 1'b1;
         ram_wdata = ram_rd_a | bit_mask(bsel);
      end
      else if (is_hl_op)
      begin
         ram_we = 1'b1;
         ram_wdata = ram_rd_a & ~bit_mask(bsel);
      end
      else if (is_mem2 && sub_op == `SUB_SET)
      begin
         ram_we = 1'b1;
         ram_wdata = ram_rd_a | bit_mask(bsel);
      end
      else if (bus_wr && mem_hit)
      begin
         ram_we = 1'b1;
         ram_waddr = avs_address[9:2];
         ram_wdata = avs_writedata[3:0];
      end
   end

   data_nibble_ram #(.ADDR_W(8)) u_ram (
      .clock(clock),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr_a(ram_raddr_a),
      .raddr_b(avs_address[9:2]),
      .rdata_a(ram_rd_a),
      .rdata_b(ram_rd_b)
   );

   // ==========================================================
   // Ports
   assign port_sel = is_port2 ? operand : {`PTR_PORT_HI, low_pointer_q[3:2]};
   assign port_bit = is_port2 ? bsel : low_pointer_q[1:0];
   assign port_pin_only = !is_port2;
   assign port_set_en = (is_port2 && sub_op == `SUB_SET) ||
      (exec_one && ins_byte == `OP_SET_PTR);

   bit_port_bank #(.NPORT(16), .OUT_MASK(OUT_PORT_MASK)) u_ports (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_en(port_set_en),
      .set_port(port_sel),
      .set_bit(port_bit),
      .rd_port(port_sel),
      .rd_bit(port_bit),
      .rd_pin_only(port_pin_only),
      .pin_in(port_pin_in),
      .latch_out(port_latch_out),
      .rd_value(port_val)
   );

   // ==========================================================
   // Fetch, flags, pointer and bus registers
   always_comb
   begin
      st_d = st_q;
      first_d = first_q;
      flags_d = flags_q;
      hi_ptr_d = hi_ptr_q;
      low_pointer_d = low_pointer_q;
      if (ins_valid && st_q == bitman_pkg::ST_FIRST && !exec_one)
      begin
         st_d = bitman_pkg::ST_SECOND;
         first_d = ins_byte;
      end
      else if (exec_two)
      begin
         st_d = bitman_pkg::ST_FIRST;
      end
      if (exec_one)
      begin
         case (ins_byte)
            `OP_TEST_POSITIVE_OP_CF:
            begin
               flags_d[`FLAG_SF] = flags_q[`FLAG_CF];
               flags_d[`FLAG_CF] = 1'b1;
            end
            `OP_TEST_POSITIVE_OP_ZF: flags_d[`FLAG_SF] = flags_q[`FLAG_ZF];
            `OP_TEST_POSITIVE_OP_GF: flags_d[`FLAG_SF] = flags_q[`FLAG_GF];
            `OP_SET_GF: flags_d[`FLAG_SF] = 1'b1;
            `OP_CLR_GF: flags_d[`FLAG_SF] = 1'b1;
            `OP_TEST_PTR: flags_d[`FLAG_SF] = ~port_val;
            `OP_SET_PTR: flags_d[`FLAG_SF] = 1'b1;
            default: flags_d[`FLAG_SF] = is_hl_op ? 1'b1 : flags_q[`FLAG_SF];
         endcase
         if (ins_byte == `OP_SET_GF)
         begin
            flags_d[`FLAG_GF] = 1'b1;
         end
         if (ins_byte == `OP_CLR_GF)
         begin
            flags_d[`FLAG_GF] = 1'b0;
         end
      end
      else if (exec_two)
      begin
         case (sub_op)
            `SUB_TEST: flags_d[`FLAG_SF] = is_mem2 ? ~mem_bit : ~port_val;
            `SUB_TEST_POSITIVE_OP: flags_d[`FLAG_SF] = is_mem2 ? mem_bit : port_val;
            `SUB_SET: flags_d[`FLAG_SF] = 1'b1;
            default: flags_d[`FLAG_SF] = flags_q[`FLAG_SF];
         endcase
      end
      else if (bus_wr && avs_address == `REG_FLAGS)
      begin
         flags_d = avs_writedata[3:0];
      end
      if (bus_wr && avs_address == `REG_POINTER)
      begin
         {hi_ptr_d, low_pointer_d} = avs_writedata[7:0];
      end
   end

   // Reads take two cycles so that read data always comes from a flop
   always_comb
   begin
      rd_done_d = avs_read && !rd_done_q;
      rdata_d = rdata_q;
      if (avs_read && !rd_done_q)
      begin
         if (mem_hit)
         begin
            rdata_d = {28'h0, ram_rd_b};
         end
         else
         begin
            case (avs_address)
               `REG_FLAGS: rdata_d = {28'h0, flags_q};
               `REG_POINTER: rdata_d = {24'h0, hi_ptr_q, low_pointer_q};
               `REG_STATUS: rdata_d = {23'h0, st_q == bitman_pkg::ST_SECOND, first_q};
               default: rdata_d = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_q <= bitman_pkg::ST_FIRST;
         first_q <= `FIRST_RESET;
         flags_q <= `FLAGS_RESET;
         hi_ptr_q <= `POINTER_RESET;
         low_pointer_q <= `POINTER_RESET;
         rd_done_q <= 1'b0;
         rdata_q <= 32'h0;
      end
      else
      begin
         st_q <= st_d;
         first_q <= first_d;
         flags_q <= flags_d;
         hi_ptr_q <= hi_ptr_d;
         low_pointer_q <= low_pointer_d;
         rd_done_q <= rd_done_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest = avs_read ? !rd_done_q : (avs_write && exec_any);
   assign avs_readdata = rdata_q;
   assign status_flag = flags_q[`FLAG_SF];
   assign carry_flag = flags_q[`FLAG_CF];
   assign zero_flag = flags_q[`FLAG_ZF];
   assign general_flag = flags_q[`FLAG_GF];

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   AST_TEST_MEM: assert property ((is_mem2 && sub_op == `SUB_TEST)
      |=> status_flag == !$past(mem_bit)) else $error("memory test status wrong");
   AST_PORT_SOURCE: assert property (is_port2 |-> port_val ==
      (OUT_PORT_MASK[operand] ? port_latch_out[{operand, bsel}] : port_pin_in[{operand, bsel}]))
      else $error("port bit source wrong");
   AST_TEST_PORT: assert property ((is_port2 && sub_op == `SUB_TEST)
      |=> status_flag == !$past(port_val)) else $error("port test status wrong");
   AST_TEST_PTR: assert property ((exec_one && ins_byte == `OP_TEST_PTR)
      |=> status_flag == !$past(port_pin_in[{`PTR_PORT_HI, low_pointer_q}]))
      else $error("pointer port test wrong");
   AST_TEST_POSITIVE_OP_CF: assert property ((exec_one && ins_byte == `OP_TEST_POSITIVE_OP_CF)
      |=> status_flag == $past(carry_flag) && carry_flag) else $error("carry test wrong");
   AST_TEST_POSITIVE_OP_ZF: assert property ((exec_one && ins_byte == `OP_TEST_POSITIVE_OP_ZF)
      |=> status_flag == $past(zero_flag) && $stable(carry_flag) && $stable(general_flag))
      else $error("zero test wrong");
   AST_TEST_POSITIVE_OP_GF: assert property ((exec_one && ins_byte == `OP_TEST_POSITIVE_OP_GF)
      |=> status_flag == $past(general_flag)) else $error("general test wrong");
   AST_TEST_POSITIVE_OP_MEM: assert property ((is_mem2 && sub_op == `SUB_TEST_POSITIVE_OP)
      |=> status_flag == $past(mem_bit)) else $error("memory positive test wrong");
   AST_TEST_POSITIVE_OP_PORT: assert property ((is_port2 && sub_op == `SUB_TEST_POSITIVE_OP)
      |=> status_flag == $past(port_val)) else $error("port positive test wrong");
   AST_SET_GF: assert property ((exec_one && ins_byte == `OP_SET_GF)
      |=> general_flag && status_flag) else $error("general set wrong");
   AST_CLR_GF: assert property ((exec_one && ins_byte == `OP_CLR_GF)
      |=> !general_flag && status_flag) else $error("general clear wrong");
   AST_SET_HL: assert property ((is_hl_op && !ins_byte[`OP_HL_CLR_POS])
      |-> ram_we && ram_waddr == {hi_ptr_q, low_pointer_q} && ram_wdata[bsel] ##1 status_flag)
      else $error("pointer pair set wrong");
   AST_SET_MEM: assert property ((is_mem2 && sub_op == `SUB_SET)
      |-> ram_we && ram_waddr == {`PAGE0_HI, operand} && ram_wdata[bsel] ##1 status_flag)
      else $error("page-0 set wrong");
   AST_SET_PORT: assert property ((is_port2 && sub_op == `SUB_SET)
      |=> port_latch_out[$past({operand, bsel})] && status_flag) else $error("port set wrong");
   AST_SET_PTR: assert property ((exec_one && ins_byte == `OP_SET_PTR)
      |=> port_latch_out[$past({`PTR_PORT_HI, low_pointer_q})]) else $error("ptr set wrong");
   AST_CLR_HL: assert property ((is_hl_op && ins_byte[`OP_HL_CLR_POS])
      |-> ram_we && ram_waddr == {hi_ptr_q, low_pointer_q} && !ram_wdata[bsel])
      else $error("pointer pair clear wrong");

   COV_TWO_BYTE_TEST: cover property (is_mem2 && sub_op == `SUB_TEST);
   COV_PTR_SET_THEN_TEST: cover property ((exec_one && ins_byte == `OP_SET_PTR) ##1
      (exec_one && ins_byte == `OP_TEST_PTR));
   COV_BUS_WRITE_STALL: cover property (avs_write && avs_waitrequest);

endmodule

`default_nettype wire

/* tb/prog_mem_model.sv */
// Program memory model that feeds instruction bytes to the execute unit
`timescale 1ns/1ps
`default_nettype none

module prog_mem_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [5:0] count,
   input wire logic slow,
   input wire logic ins_ready,
   output logic ins_valid,
   output logic [7:0] ins_byte,
   output logic busy
);
   logic [7:0] rom [0:63];
   logic [5:0] idx_q;

   // ==========================================================
   // Byte sequencer
   // Idle byte lines toggle so that a stale opcode never looks valid
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         busy <= 1'b0;
         ins_valid <= 1'b0;
         ins_byte <= 8'h00;
         idx_q <= 6'h00;
      end
      else if (!busy)
      begin
         ins_valid <= 1'b0;
         ins_byte <= ~ins_byte;
         busy <= start;
         idx_q <= 6'h00;
      end
      else if (!(ins_valid && !ins_ready))
      begin
         // Slow mode leaves one idle cycle between bytes
         if (idx_q == count || (slow && ins_valid))
         begin
            ins_valid <= 1'b0;
            ins_byte <= ~ins_byte;
            busy <= (idx_q != count);
         end
         else
         begin
            ins_valid <= 1'b1;
            ins_byte <= rom[idx_q];
            idx_q <= idx_q + 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the bit-manipulation execute unit
`timescale 1ns/1ps
`default_nettype none
`include "bitman_consts.svh"

module testbench;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic start = 1'b0;
   logic slow = 1'b0;
   logic [5:0] count = 6'h00;
   logic ins_valid, ins_ready, busy;
   logic [7:0] ins_byte;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest;
   logic [63:0] port_pin_in = 64'h0;
   logic [63:0] port_latch_out;
   logic status_flag, carry_flag, zero_flag, general_flag;
   logic [3:0] flags;
   logic e;
   int n_mismatch = 0;
   int cmp_count = 0;
   // {preset flags, opcode, expected flags}
   logic [15:0] flag_tab [8] = '{16'h0041, 16'h1049, 16'h20ea, 16'hd0e5,
      16'h003c, 16'h401c, 16'h4028, 16'h8010};
   // {expected status, second byte}
   logic [8:0] port_tab [5] = '{9'h092, 9'h1d2, 9'h0a6, 9'h0e5, 9'h1c6};

   assign flags = {status_flag, general_flag, zero_flag, carry_flag};

   always #5 clock = ~clock;

   bit_manipulation_exec_unit dut (.clock(clock), .sys_rst(sys_rst), .ins_valid(ins_valid),
      .ins_byte(ins_byte), .ins_ready(ins_ready), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port_pin_in(port_pin_in),
      .port_latch_out(port_latch_out), .status_flag(status_flag), .carry_flag(carry_flag),
      .zero_flag(zero_flag), .general_flag(general_flag));

   prog_mem_model pm (.clock(clock), .sys_rst(sys_rst), .start(start), .count(count),
      .slow(slow), .ins_ready(ins_ready), .ins_valid(ins_valid), .ins_byte(ins_byte),
      .busy(busy));

   // ==========================================================
   // Shared tasks
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s timed out", $time, what);
      end_of_test();
   endtask

   // Request held until a rising edge with waitrequest low
   // Sampled at the edge itself, before the flops update
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge clock);
      end
      if (n == 50)
         hang("bus");
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string w);
      bus(1'b0, a, 32'h0);
      check(rd, exp, w);
   endtask

   function automatic logic [11:0] ma(input logic [7:0] a);
      return 12'h400 + {2'b00, a, 2'b00};
   endfunction

   // Effects are registered by the edge that drops busy
   task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [5:0] n);
      int k = 0;
      pm.rom[0] = b0;
      pm.rom[1] = b1;
      @(posedge clock);
      count <= n;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      @(negedge clock);
      while (busy !== 1'b0 && k < 50)
      begin
         k++;
         @(negedge clock);
      end
      if (k == 50)
         hang("program");
      @(posedge clock);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      rd_chk(`REG_FLAGS, 32'h0, "flags after reset");
      check(port_latch_out, 64'h0, "latches after reset");
      bus(1'b1, 12'h00c, 32'hffffffff);
      rd_chk(12'h00c, 32'h0, "unmapped read");
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, `REG_FLAGS, {28'h0, flag_tab[i][15:12]});
         slow <= i[0];
         run(flag_tab[i][11:4], 8'h00, 6'd1);
         check(flags, flag_tab[i][3:0], "flag op");
      end
      bus(1'b1, ma(8'h03), 32'ha);
      for (int i = 0; i < 8; i++)
      begin
         e = 1'(4'ha >> i[1:0]) ^ !i[2];
         bus(1'b1, `REG_FLAGS, {28'h0, ~e, 3'b000});
         slow <= i[0];
         run(8'h39, {1'b1, i[2], i[1:0], 4'h3}, 6'd2);
         check(flags, {e, 3'b000}, "memory bit test");
      end
      bus(1'b1, ma(8'h05), 32'h0);
      bus(1'b1, `REG_FLAGS, 32'h0);
      run(8'h39, 8'h00, 6'd1);
      rd_chk(`REG_STATUS, 32'h139, "prefix held");
      run(8'h15, 8'h00, 6'd1);
      rd_chk(ma(8'h05), 32'h2, "direct set");
      check(flags, 4'h8, "direct set status");
      run(8'h39, 8'h55, 6'd2);
      rd_chk(ma(8'h05), 32'h2, "clear sub-op ignored");
      bus(1'b1, `REG_POINTER, 32'h26);
      bus(1'b1, ma(8'h26), 32'h0);
      bus(1'b1, `REG_FLAGS, 32'h0);
      run(8'h53, 8'h51, 6'd2);
      rd_chk(ma(8'h26), 32'ha, "pair set");
      check(flags, 4'h8, "pair set status");
      run(8'h57, 8'h00, 6'd1);
      rd_chk(ma(8'h26), 32'h2, "pair clear");
      bus(1'b1, `REG_FLAGS, 32'h0);
      port_pin_in <= 64'h0500_0000;
      run(8'h3b, 8'h12, 6'd2);
      check(port_latch_out, 64'h200, "port set");
      check(flags, 4'h8, "port set status");
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b1, `REG_FLAGS, {28'h0, ~port_tab[i][8], 3'b000});
         run(8'h3b, port_tab[i][7:0], 6'd2);
         check(flags, {port_tab[i][8], 3'b000}, "port bit test");
      end
      bus(1'b1, `REG_POINTER, 32'h09);
      bus(1'b1, `REG_FLAGS, 32'h0);
      run(8'h34, 8'h37, 6'd2);
      check(port_latch_out, 64'h0200_0200, "pointer port set");
      check(flags, 4'h8, "pointer test reads pin");
      bus(1'b1, `REG_POINTER, 32'h0a);
      run(8'h37, 8'h00, 6'd1);
      check(flags, 4'h0, "pointer test bit two");
      // Write meets an executing byte: it must wait, not be lost
      fork
         run(8'h03, 8'h00, 6'd1);
         begin
            repeat (2) @(posedge clock);
            bus(1'b1, `REG_FLAGS, 32'h1);
         end
      join
      rd_chk(`REG_FLAGS, 32'h1, "write stalled behind instruction");
      end_of_test();
   end
endmodule
`default_nettype wire
